// file: hw/limit_alert_pkg.sv
// limit_alert_pkg: register offsets, bit positions, reset values and channel indices
// for the limit status and alert logic.
// assumes: used only by limit_status_alert_logic; its two leaf modules do not refer to it.

package limit_alert_pkg;

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [7:0] status_primary_addr   = 8'h41;
	localparam logic [7:0] status_secondary_addr = 8'h42;
	localparam logic [7:0] mask_primary_addr     = 8'h74;
	localparam logic [7:0] mask_secondary_addr   = 8'h75;
	localparam logic [7:0] config_three_addr     = 8'h78;
	localparam logic [7:0] config_four_addr      = 8'h7d;

	// ****************************************************************
	// primary status / mask bit positions
	// ****************************************************************
	localparam int rail_2v5_bit        = 0;
	localparam int supply_bit          = 2;
	localparam int remote_one_temp_bit = 4;
	localparam int local_temp_bit      = 5;
	localparam int remote_two_temp_bit = 6;
	localparam int summary_bit         = 7;

	// ****************************************************************
	// secondary status / mask bit positions
	// ****************************************************************
	localparam int overtemp_bit         = 1;
	localparam int first_fan_bit        = 2;
	localparam int second_fan_bit       = 3;
	localparam int third_fan_bit        = 4;
	localparam int fourth_fan_timer_bit = 5;
	localparam int diode_one_bit        = 6;
	localparam int diode_two_bit        = 7;

	// ****************************************************************
	// configuration bit positions
	// ****************************************************************
	localparam int alert_pin_enable_bit = 0;
	localparam int thermal_enable_bit   = 1;

	// ****************************************************************
	// implemented bits and reset values
	// ****************************************************************
	localparam logic [7:0] primary_used_bits   = 8'hf5;
	localparam logic [7:0] secondary_used_bits = 8'hfe;
	localparam logic [7:0] mask_reset          = 8'h00;
	localparam logic [7:0] config_reset        = 8'h00;
	localparam logic [7:0] unmapped_read_value = 8'h00;

	// ****************************************************************
	// channel indices and widths
	// ****************************************************************
	localparam int analog_channels = 5;
	localparam int fan_channels    = 4;
	localparam int analog_width    = 8;
	localparam int tach_width      = 16;
	localparam int ch_rail_2v5     = 0;
	localparam int ch_supply       = 1;
	localparam int ch_remote_one   = 2;
	localparam int ch_local        = 3;
	localparam int ch_remote_two   = 4;

endpackage : limit_alert_pkg

// file: hw/limit_compare.sv
// limit_compare: holds the result of the latest limit comparison of one channel.
// assumes: value and limits are stable in the cycle sample is high, same clock.

`timescale 1ns/1ps
`default_nettype none

module limit_compare #(
	parameter int WIDTH   = 8,
	parameter bit HAS_LOW = 1'b1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// measurement
	input  wire logic             sample,
	input  wire logic [WIDTH-1:0] value,
	input  wire logic [WIDTH-1:0] low_limit,
	input  wire logic [WIDTH-1:0] high_limit,
	// result
	output logic                  out_of_limit
);

	// ****************************************************************
	// elaboration check
	// ****************************************************************
	if (WIDTH < 1 || WIDTH > 32)
	begin : g_bad_width
		$error("limit_compare: WIDTH must lie in 1..32");
	end

	logic out_of_limit_ff;
	logic nxt_out_of_limit;

	// high limit is strictly greater, low limit includes equality
	always_comb
	begin
		nxt_out_of_limit = out_of_limit_ff;
		if (sample)
		begin
			nxt_out_of_limit = (value > high_limit) ||
				(HAS_LOW && (value <= low_limit));
		end
	end

	// result stands until the next measurement of this channel
	always_ff @(posedge clk)
	begin
		if (!nrst)
			out_of_limit_ff <= 1'b0;
		else
			out_of_limit_ff <= nxt_out_of_limit;
	end

	assign out_of_limit = out_of_limit_ff;

endmodule : limit_compare

`default_nettype wire

// file: hw/limit_status_alert_logic.sv
// limit_status_alert_logic: limit comparison results, sticky status, masks and alert pins.
// assumes: an smbus slave elsewhere turns register reads and writes into one-cycle strobes;
// measurements, limits and fault levels come from logic on the same clock.
//
// Function
// - a flag becomes 1 when the latest comparison of its channel is out of limits
// - primary bit 7 reads 1 while any secondary flag is set
// - primary layout: remote two 6, local 5, remote one 4, supply 2, rail 0
// - secondary bits 4, 3, 2 flag third, second, first fan slow
// - secondary bits 7 and 6 flag second and first diode faults
// - secondary bit 5 flags fourth fan slow or thermal timer limit
// - secondary bit 1 flags any overtemperature limit exceeded
// - flags are sticky until read after their cause has gone
// - a status read clears only flags whose cause is gone
// - alert stays low while an unmasked reading is bad and until read
// - a mask bit blocks only the alert, never the flag
// - primary mask mirrors primary status; bit 7 masks every secondary source
// - secondary mask mirrors secondary status; bit 5 covers fan or thermal
// - after reset no pin acts as alert output
// - config four bit 0 turns the rail input pin into the alert
// - config three bit 0 turns the other pin into the alert
// - high limit compares greater than, low limit less than or equal
// - fan flags rise when the 16-bit tach period exceeds its limit

`timescale 1ns/1ps
`default_nettype none

module limit_status_alert_logic #(
	parameter int ANALOG_CHANNELS = limit_alert_pkg::analog_channels,
	parameter int FAN_CHANNELS    = limit_alert_pkg::fan_channels
) (
	// clock and reset
	input  wire logic                                   clk,
	input  wire logic                                   nrst,
	// register access from the serial interface
	input  wire logic [7:0]                             reg_addr,
	input  wire logic                                   reg_wr,
	input  wire logic [7:0]                             reg_wdata,
	input  wire logic                                   reg_rd,
	output logic      [7:0]                             reg_rdata,
	output logic                                        reg_ack,
	// analog measurements: rail, supply, remote one, local, remote two
	input  wire logic [ANALOG_CHANNELS-1:0]             analog_sample,
	input  wire logic [ANALOG_CHANNELS-1:0][7:0]        analog_value,
	input  wire logic [ANALOG_CHANNELS-1:0][7:0]        analog_low_limit,
	input  wire logic [ANALOG_CHANNELS-1:0][7:0]        analog_high_limit,
	// fan tachometer periods and their limits
	input  wire logic [FAN_CHANNELS-1:0]                tach_sample,
	input  wire logic [FAN_CHANNELS-1:0][15:0]          tach_period,
	input  wire logic [FAN_CHANNELS-1:0][15:0]          tach_limit,
	// fault levels
	input  wire logic                                   diode_one_fault,
	input  wire logic                                   diode_two_fault,
	input  wire logic                                   overtemp_cond,
	input  wire logic                                   thermal_timer_limit_hit,
	// alert pins, open drain
	output logic                                        rail_pin_out,
	output logic                                        rail_pin_oe,
	output logic                                        other_pin_out,
	output logic                                        other_pin_oe,
	// configuration towards the rest of the chip
	output logic      [7:0]                             config_three_value,
	output logic      [7:0]                             config_four_value,
	output logic                                        thermal_pin_mode
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (ANALOG_CHANNELS != limit_alert_pkg::analog_channels ||
		FAN_CHANNELS != limit_alert_pkg::fan_channels)
	begin : g_bad_layout
		$error("limit_status_alert_logic: status layout serves five analog channels, four fans");
	end

	// ****************************************************************
	// configuration and mask registers
	// ****************************************************************
	logic [7:0] alert_mask_primary_ff;
	logic [7:0] alert_mask_secondary_ff;
	logic [7:0] config_three_ff;
	logic [7:0] config_four_ff;
	logic       wr_mask_primary;
	logic       wr_mask_secondary;
	logic       wr_config_three;
	logic       wr_config_four;

	assign wr_mask_primary   = reg_wr && (reg_addr == limit_alert_pkg::mask_primary_addr);
	assign wr_mask_secondary = reg_wr && (reg_addr == limit_alert_pkg::mask_secondary_addr);
	assign wr_config_three   = reg_wr && (reg_addr == limit_alert_pkg::config_three_addr);
	assign wr_config_four    = reg_wr && (reg_addr == limit_alert_pkg::config_four_addr);

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			alert_mask_primary_ff   <= limit_alert_pkg::mask_reset;
			alert_mask_secondary_ff <= limit_alert_pkg::mask_reset;
			// alert function stays off until software sets an enable bit
			config_three_ff         <= limit_alert_pkg::config_reset;
			config_four_ff          <= limit_alert_pkg::config_reset;
		end
		else
		begin
			if (wr_mask_primary)
				alert_mask_primary_ff <= reg_wdata & limit_alert_pkg::primary_used_bits;
			if (wr_mask_secondary)
				alert_mask_secondary_ff <= reg_wdata & limit_alert_pkg::secondary_used_bits;
			if (wr_config_three)
				config_three_ff <= reg_wdata;
			if (wr_config_four)
				config_four_ff <= reg_wdata;
		end
	end

	logic alert_on_rail_pin_enable;
	logic alert_on_other_pin_enable;

	assign alert_on_rail_pin_enable  = config_four_ff[limit_alert_pkg::alert_pin_enable_bit];
	assign alert_on_other_pin_enable = config_three_ff[limit_alert_pkg::alert_pin_enable_bit];
	assign thermal_pin_mode          = config_three_ff[limit_alert_pkg::thermal_enable_bit];
	assign config_three_value        = config_three_ff;
	assign config_four_value         = config_four_ff;

	// ****************************************************************
	// limit comparisons
	// ****************************************************************
	logic [ANALOG_CHANNELS-1:0] analog_take;
	logic [ANALOG_CHANNELS-1:0] analog_ool;
	logic [FAN_CHANNELS-1:0]    fan_slow;

	// a rail pin given over to the alert no longer measures, so its
	// stale result must not be refreshed
	always_comb
	begin
		analog_take = analog_sample;
		analog_take[limit_alert_pkg::ch_rail_2v5] =
			analog_sample[limit_alert_pkg::ch_rail_2v5] & ~alert_on_rail_pin_enable;
	end

	for (genvar a = 0; a < ANALOG_CHANNELS; a++)
	begin : g_analog
		limit_compare #(
			.WIDTH   (limit_alert_pkg::analog_width),
			.HAS_LOW (1'b1)
		) u_cmp (
			.clk          (clk),
			.nrst         (nrst),
			.sample       (analog_take[a]),
			.value        (analog_value[a]),
			.low_limit    (analog_low_limit[a]),
			.high_limit   (analog_high_limit[a]),
			.out_of_limit (analog_ool[a])
		);
	end

	// fans have only an upper period limit: long period means slow or stalled
	for (genvar f = 0; f < FAN_CHANNELS; f++)
	begin : g_fan
		limit_compare #(
			.WIDTH   (limit_alert_pkg::tach_width),
			.HAS_LOW (1'b0)
		) u_cmp (
			.clk          (clk),
			.nrst         (nrst),
			.sample       (tach_sample[f]),
			.value        (tach_period[f]),
			.low_limit    ('0),
			.high_limit   (tach_limit[f]),
			.out_of_limit (fan_slow[f])
		);
	end

	// ****************************************************************
	// status sources
	// ****************************************************************
	logic [7:0] primary_cond;
	logic [7:0] secondary_cond;
	logic       fourth_fan_or_timer_cond;

	// fourth tach pin serves either the fan or the thermal timer
	assign fourth_fan_or_timer_cond = thermal_pin_mode ? thermal_timer_limit_hit : fan_slow[3];

	always_comb
	begin
		primary_cond = 8'h00;
		primary_cond[limit_alert_pkg::rail_2v5_bit] =
			analog_ool[limit_alert_pkg::ch_rail_2v5];
		primary_cond[limit_alert_pkg::supply_bit] =
			analog_ool[limit_alert_pkg::ch_supply];
		primary_cond[limit_alert_pkg::remote_one_temp_bit] =
			analog_ool[limit_alert_pkg::ch_remote_one];
		primary_cond[limit_alert_pkg::local_temp_bit] =
			analog_ool[limit_alert_pkg::ch_local];
		primary_cond[limit_alert_pkg::remote_two_temp_bit] =
			analog_ool[limit_alert_pkg::ch_remote_two];
	end

	always_comb
	begin
		secondary_cond = 8'h00;
		secondary_cond[limit_alert_pkg::overtemp_bit]         = overtemp_cond;
		secondary_cond[limit_alert_pkg::first_fan_bit]        = fan_slow[0];
		secondary_cond[limit_alert_pkg::second_fan_bit]       = fan_slow[1];
		secondary_cond[limit_alert_pkg::third_fan_bit]        = fan_slow[2];
		secondary_cond[limit_alert_pkg::fourth_fan_timer_bit] = fourth_fan_or_timer_cond;
		secondary_cond[limit_alert_pkg::diode_one_bit]        = diode_one_fault;
		secondary_cond[limit_alert_pkg::diode_two_bit]        = diode_two_fault;
	end

	// ****************************************************************
	// sticky status registers
	// ****************************************************************
	logic       rd_status_primary;
	logic       rd_status_secondary;
	logic [7:0] primary_flags;
	logic [7:0] secondary_flags;
	logic       secondary_flag_summary;
	logic [7:0] limit_status_primary;

	assign rd_status_primary   = reg_rd && (reg_addr == limit_alert_pkg::status_primary_addr);
	assign rd_status_secondary = reg_rd && (reg_addr == limit_alert_pkg::status_secondary_addr);

	// summary is derived, not stored; reading either register never drops it early
	sticky_flag_bank #(
		.WIDTH (8),
		.USED  (limit_alert_pkg::primary_used_bits & 8'h7f)
	) u_primary (
		.clk        (clk),
		.nrst       (nrst),
		.cond       (primary_cond),
		.read_clear (rd_status_primary),
		.flags      (primary_flags)
	);

	sticky_flag_bank #(
		.WIDTH (8),
		.USED  (limit_alert_pkg::secondary_used_bits)
	) u_secondary (
		.clk        (clk),
		.nrst       (nrst),
		.cond       (secondary_cond),
		.read_clear (rd_status_secondary),
		.flags      (secondary_flags)
	);

	assign secondary_flag_summary = |secondary_flags;

	always_comb
	begin
		limit_status_primary = primary_flags;
		limit_status_primary[limit_alert_pkg::summary_bit] = secondary_flag_summary;
	end

	// ****************************************************************
	// alert generation
	// ****************************************************************
	logic alert_primary_src;
	logic alert_secondary_src;
	logic nxt_alert;
	logic rail_pin_oe_ff;
	logic other_pin_oe_ff;

	// masks act on the alert only; the flags above never see them
	assign alert_primary_src = |(primary_flags & ~alert_mask_primary_ff);
	assign alert_secondary_src = ~alert_mask_primary_ff[limit_alert_pkg::summary_bit] &
		(|(secondary_flags & ~alert_mask_secondary_ff));
	assign nxt_alert = alert_primary_src | alert_secondary_src;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			rail_pin_oe_ff  <= 1'b0;
			other_pin_oe_ff <= 1'b0;
		end
		else
		begin
			rail_pin_oe_ff  <= nxt_alert & alert_on_rail_pin_enable;
			other_pin_oe_ff <= nxt_alert & alert_on_other_pin_enable;
		end
	end

	// open drain: the pin is only ever pulled low
	assign rail_pin_out  = 1'b0;
	assign other_pin_out = 1'b0;
	assign rail_pin_oe   = rail_pin_oe_ff;
	assign other_pin_oe  = other_pin_oe_ff;

	// ****************************************************************
	// register read path
	// ****************************************************************
	logic [7:0] nxt_rdata;
	logic [7:0] reg_rdata_ff;
	logic       reg_ack_ff;

	// flags are sampled before the clear of the same read takes effect
	always_comb
	begin
		unique case (reg_addr)
			limit_alert_pkg::status_primary_addr:   nxt_rdata = limit_status_primary;
			limit_alert_pkg::status_secondary_addr: nxt_rdata = secondary_flags;
			limit_alert_pkg::mask_primary_addr:     nxt_rdata = alert_mask_primary_ff;
			limit_alert_pkg::mask_secondary_addr:   nxt_rdata = alert_mask_secondary_ff;
			limit_alert_pkg::config_three_addr:     nxt_rdata = config_three_ff;
			limit_alert_pkg::config_four_addr:      nxt_rdata = config_four_ff;
			default:                                nxt_rdata = limit_alert_pkg::unmapped_read_value;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
			reg_rdata_ff <= 8'h00;
		else if (reg_rd)
			reg_rdata_ff <= nxt_rdata;
	end

	// writes to status offsets are acknowledged and dropped
	always_ff @(posedge clk)
	begin
		if (!nrst)
			reg_ack_ff <= 1'b0;
		else
			reg_ack_ff <= reg_rd | reg_wr;
	end

	assign reg_rdata = reg_rdata_ff;
	assign reg_ack   = reg_ack_ff;

endmodule : limit_status_alert_logic

`default_nettype wire

// file: hw/sticky_flag_bank.sv
// sticky_flag_bank: one status register of sticky flags, cleared by read.
// assumes: cond is a level from same-clock logic; read_clear is a one-cycle strobe.

`timescale 1ns/1ps
`default_nettype none

module sticky_flag_bank #(
	parameter int               WIDTH = 8,
	parameter logic [WIDTH-1:0] USED  = '1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// sources
	input  wire logic [WIDTH-1:0] cond,
	input  wire logic             read_clear,
	// flags
	output logic      [WIDTH-1:0] flags
);

	if (WIDTH < 1)
	begin : g_bad_width
		$error("sticky_flag_bank: WIDTH must be at least 1");
	end

	// ****************************************************************
	// one flop per implemented bit
	// ****************************************************************
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		if (USED[i])
		begin : g_flag
			logic flag_ff;
			logic nxt_flag;
			// a live condition wins over the clear of the same read
			assign nxt_flag = cond[i] | (flag_ff & ~read_clear);
			always_ff @(posedge clk)
			begin
				if (!nrst)
					flag_ff <= 1'b0;
				else
					flag_ff <= nxt_flag;
			end
			assign flags[i] = flag_ff;
		end
		else
		begin : g_unused
			assign flags[i] = 1'b0;
		end
	end

endmodule : sticky_flag_bank

`default_nettype wire

// file: tb/host_model.sv
// host_model: register-port master standing in for the serial slave.
// assumes: one-cycle strobes, ack one cycle after the strobe edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// clock
	input  wire logic       clk,
	// register port
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_ack
);
	initial
		{reg_addr, reg_wr, reg_wdata, reg_rd} = 18'h0;
	// a missing ack returns unknown data so the caller's compare fails
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] wd,
		output logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = wd;
		reg_wr = w;
		reg_rd = !w;
		@(posedge clk);
		#1;
		d = (reg_ack === 1'b1) ? reg_rdata : 8'hxx;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		// released lines show the inverse, never the old value
		reg_addr = ~a;
		reg_wdata = ~wd;
	endtask : xfer
endmodule : host_model
`default_nettype wire

// file: tb/limit_alert_properties.sv
// limit_alert_properties: port-level checks of status reads and alert pins.
// assumes: bound to limit_status_alert_logic; one clock, sync active-low reset.
`timescale 1ns/1ps
`default_nettype none
module limit_alert_properties (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       diode_one_fault,
	input wire logic       diode_two_fault,
	input wire logic       overtemp_cond,
	input wire logic       rail_pin_oe,
	input wire logic       other_pin_oe,
	input wire logic [7:0] config_three_value,
	input wire logic [7:0] config_four_value
);
	logic rd_one;
	logic rd_two;
	assign rd_one = reg_rd && reg_addr == 8'h41;
	assign rd_two = reg_rd && reg_addr == 8'h42;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	diode_two_seen_a: assert property
		(diode_two_fault ##1 rd_two |=> reg_rdata[7]) else $error("diode two flag missing");
	diode_one_seen_a: assert property
		(diode_one_fault ##1 rd_two |=> reg_rdata[6]) else $error("diode one flag missing");
	overtemp_seen_a: assert property
		(overtemp_cond ##1 rd_two |=> reg_rdata[1]) else $error("overtemp flag missing");
	summary_bit_a: assert property
		(diode_one_fault ##1 rd_one |=> reg_rdata[7]) else $error("summary bit missing");
	unused_zero_a: assert property
		(rd_one |=> !reg_rdata[3] && !reg_rdata[1]) else $error("unused primary bit set");
	unused_two_a: assert property
		(rd_two |=> !reg_rdata[0]) else $error("unused secondary bit set");
	unmapped_zero_a: assert property
		(reg_rd && !(reg_addr inside {8'h41, 8'h42, 8'h74, 8'h75, 8'h78, 8'h7d})
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	reset_quiet_a: assert property
		($rose(nrst) |-> !rail_pin_oe && !other_pin_oe) else $error("alert after reset");
	rail_enable_a: assert property
		(rail_pin_oe |-> $past(config_four_value[0])) else $error("rail pin not enabled");
	other_enable_a: assert property
		(other_pin_oe |-> $past(config_three_value[0])) else $error("other pin not enabled");
	cover property (rail_pin_oe);
	cover property (other_pin_oe);
	cover property (diode_two_fault ##1 rd_two);
endmodule : limit_alert_properties
bind limit_status_alert_logic limit_alert_properties i_limit_alert_properties (
	.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.diode_one_fault(diode_one_fault), .diode_two_fault(diode_two_fault),
	.overtemp_cond(overtemp_cond), .rail_pin_oe(rail_pin_oe), .other_pin_oe(other_pin_oe),
	.config_three_value(config_three_value), .config_four_value(config_four_value));
`default_nettype wire

// file: tb/limit_status_alert_logic_tb.sv
// limit_status_alert_logic_tb: directed scenarios for status, masks and alert pins.
// assumes: host_model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module limit_status_alert_logic_tb;
	logic             clk = 1'b0;
	logic             nrst = 1'b0;
	logic [8:0]       smp = '0;
	logic [4:0][7:0]  av = {5{8'h50}};
	logic [3:0][15:0] tp = {4{16'h0800}};
	logic [3:0]       flt = '0;
	logic [7:0]       addr, wdata, rdata, c3v, c4v;
	logic             wr, rd, ack, r_oe, o_oe, tmode, r_out, o_out;
	int               failures = 0;
	int               n_checks = 0;
	always #12.5 clk = ~clk;
	host_model i_host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
		.reg_rd(rd), .reg_rdata(rdata), .reg_ack(ack));
	limit_status_alert_logic i_limit_status_alert_logic (.clk(clk), .nrst(nrst),
		.reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
		.reg_ack(ack), .analog_sample(smp[4:0]), .analog_value(av),
		.analog_low_limit({5{8'h20}}), .analog_high_limit({5{8'h80}}),
		.tach_sample(smp[8:5]), .tach_period(tp), .tach_limit({4{16'h1000}}),
		.diode_one_fault(flt[0]), .diode_two_fault(flt[1]), .overtemp_cond(flt[2]),
		.thermal_timer_limit_hit(flt[3]), .rail_pin_out(r_out), .rail_pin_oe(r_oe),
		.other_pin_out(o_out), .other_pin_oe(o_oe), .config_three_value(c3v),
		.config_four_value(c4v), .thermal_pin_mode(tmode));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_host.xfer(1'b0, a, 8'h00, d);
		chk(d, exp);
	endtask : rdc
	task automatic wrr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] d;
		i_host.xfer(1'b1, a, v, d);
		chk({7'h0, ack}, 8'h01);
	endtask : wrr
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	// strobe waits out the compare and flag pipeline before returning
	task automatic pulse(input logic [8:0] s);
		smp = s;
		cyc(1);
		smp = '0;
		cyc(4);
	endtask : pulse
	task automatic t_regs;
		logic [7:0] a [7] = '{8'h41, 8'h42, 8'h74, 8'h75, 8'h78, 8'h7d, 8'h43};
		foreach (a[i])
			rdc(a[i], 8'h00);
		chk({6'h0, r_oe, o_oe}, 8'h00);
		wrr(8'h74, 8'hff);
		rdc(8'h74, 8'hf5);
		wrr(8'h75, 8'hff);
		rdc(8'h75, 8'hfe);
		wrr(8'h78, 8'ha4);
		wrr(8'h7d, 8'h5a);
		rdc(8'h78, 8'ha4);
		rdc(8'h7d, 8'h5a);
		chk(c3v, 8'ha4);
		chk(c4v, 8'h5a);
		wrr(8'h41, 8'hff);
		wrr(8'h42, 8'hff);
		wrr(8'h43, 8'hff);
		rdc(8'h41, 8'h00);
		rdc(8'h42, 8'h00);
		rdc(8'h43, 8'h00);
		for (int i = 2; i < 6; i++)
			wrr(a[i], 8'h00);
	endtask : t_regs
	task automatic t_analog;
		int pos [5] = '{0, 2, 4, 5, 6};
		for (int c = 0; c < 5; c++)
		begin
			av[c] = 8'h80;
			pulse(9'h1 << c);
			rdc(8'h41, 8'h00);
			av[c] = 8'h20;
			pulse(9'h1 << c);
			rdc(8'h41, 8'h01 << pos[c]);
			rdc(8'h41, 8'h01 << pos[c]);
			av[c] = 8'h50;
			pulse(9'h1 << c);
			rdc(8'h41, 8'h01 << pos[c]);
			rdc(8'h41, 8'h00);
		end
	endtask : t_analog
	task automatic t_fans;
		for (int f = 0; f < 4; f++)
		begin
			tp[f] = 16'h1000;
			pulse(9'h20 << f);
			rdc(8'h42, 8'h00);
			tp[f] = 16'h1001;
			pulse(9'h20 << f);
			rdc(8'h41, 8'h80);
			rdc(8'h42, 8'h04 << f);
			tp[f] = 16'h0800;
			pulse(9'h20 << f);
			rdc(8'h42, 8'h04 << f);
			rdc(8'h42, 8'h00);
		end
	endtask : t_fans
	task automatic t_faults;
		int pos [4] = '{6, 7, 1, 5};
		wrr(8'h78, 8'h02);
		cyc(2);
		chk({7'h0, tmode}, 8'h01);
		for (int k = 0; k < 4; k++)
		begin
			flt[k] = 1'b1;
			cyc(2);
			rdc(8'h42, 8'h01 << pos[k]);
			rdc(8'h41, 8'h80);
			flt[k] = 1'b0;
			cyc(2);
			rdc(8'h42, 8'h01 << pos[k]);
			rdc(8'h42, 8'h00);
		end
		wrr(8'h78, 8'h00);
	endtask : t_faults
	task automatic t_alert;
		wrr(8'h7d, 8'h01);
		av[1] = 8'hc0;
		pulse(9'h02);
		chk({6'h0, r_oe, o_oe}, 8'h02);
		chk({6'h0, r_out, o_out}, 8'h00);
		rdc(8'h41, 8'h04);
		wrr(8'h74, 8'h04);
		cyc(2);
		chk({6'h0, r_oe, o_oe}, 8'h00);
		rdc(8'h41, 8'h04);
		av[1] = 8'h50;
		pulse(9'h02);
		wrr(8'h74, 8'h00);
		cyc(2);
		chk({6'h0, r_oe, o_oe}, 8'h02);
		rdc(8'h41, 8'h04);
		cyc(2);
		chk({6'h0, r_oe, o_oe}, 8'h00);
		wrr(8'h7d, 8'h00);
		wrr(8'h78, 8'h01);
		flt[1] = 1'b1;
		cyc(3);
		chk({6'h0, r_oe, o_oe}, 8'h01);
		chk({6'h0, r_out, o_out}, 8'h00);
		wrr(8'h74, 8'h80);
		cyc(2);
		chk({6'h0, r_oe, o_oe}, 8'h00);
		flt[1] = 1'b0;
		rdc(8'h42, 8'h80);
		rdc(8'h42, 8'h00);
	endtask : t_alert
	// *****
	// verdict
	// *****
	task automatic summarize;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	initial
	begin
		cyc(6);
		nrst = 1'b1;
		t_regs;
		t_analog;
		t_fans;
		t_faults;
		t_alert;
		summarize;
	end
	initial
	begin
		#1000000;
		failures++;
		summarize;
	end
endmodule : limit_status_alert_logic_tb
`default_nettype wire
